// File: shared/fes_pkg.sv
// Constants and types shared by the flash erase and program sequencer.
`default_nettype none
package fes_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS    = 4'h0;
  localparam logic [3:0] PROTECT_OFS = 4'h1;
  localparam logic [3:0] STATUS_OFS  = 4'h2;

  // Control register field positions.
  localparam int CTRL_PROGRAM_ARM_BIT = 0;
  localparam int CTRL_ERASE_BIT       = 1;
  localparam int CTRL_WHOLE_BIT       = 3;
  localparam int CTRL_HV_BIT          = 4;

  // Reset values, and the protect value that leaves no block protected.
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] PROTECT_RESET = 8'hFF;
  localparam logic [7:0] PROTECT_NONE  = 8'hFF;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 16;
  localparam logic [15:0] ARRAY_BASE   = 16'hF000;
  localparam logic [15:0] ARRAY_TOP    = 16'hFFFF;
  localparam logic [15:0] TRIM_ADDR    = 16'hFFC0;
  localparam int          ROW_BYTES    = 32;
  localparam int          ROW_BITS     = 5;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_ARMED   = 5'b00010,
    ST_LATCHED = 5'b00100,
    ST_ERASE   = 5'b01000,
    ST_PROGRAM = 5'b10000
  } fes_state_t;

endpackage
`default_nettype wire

// File: src/fes_array_mem.sv
// Byte-wide nonvolatile array model with one write port and registered read.
`timescale 1ns/100ps
`default_nettype none
module fes_array_mem #(
  parameter int AW = 12
) (
  // Clock.
  input  wire logic          clock,
  // Access.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem [0:(1<<AW)-1];

  // One write port and one registered read port; erase is done by the
  // caller writing the erased value byte after byte.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// File: src/fes_sweep.sv
// Address sweep counter used to clear the whole array one byte a cycle.
`timescale 1ns/100ps
`default_nettype none
module fes_sweep #(
  parameter int AW = 12
) (
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          resetn,
  // Control.
  input  wire logic          start,
  output logic               busy,
  output logic [AW-1:0]      addr
);

  logic          busy_q, busy_d;
  logic [AW-1:0] addr_q, addr_d;

  // Runs from zero to the last address once per start.
  always_comb begin
    busy_d = busy_q;
    addr_d = addr_q;
    if (start && !busy_q) begin
      busy_d = 1'b1;
      addr_d = '0;
    end else if (busy_q) begin
      addr_d = addr_q + 1'b1;
      if (&addr_q) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      addr_q <= '0;
    end else begin
      busy_q <= busy_d;
      addr_q <= addr_d;
    end
  end

  assign busy = busy_q;
  assign addr = addr_q;

endmodule
`default_nettype wire

// File: src/fes_sequencer.sv
// Flash erase and program sequencer with register port and array model.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module fes_sequencer #(
  parameter int AW = 12
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        resetn,
  // Register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Array bus port.
  input  wire logic [15:0] arr_addr,
  input  wire logic [7:0]  arr_wdata,
  input  wire logic        arr_wr,
  input  wire logic        arr_rd,
  output logic      [7:0]  arr_rdata,
  // Monitor mode with security failed.
  input  wire logic        secure_fail,
  // Pump control and erase refusal.
  output logic             pump_on,
  output logic             erase_refused
);

  // ----------------------------------------------------------------------
  // Synchronise the security pin
  // ----------------------------------------------------------------------
  logic sec_s1_q, sec_s2_q;

  // The pin is asynchronous to the bus clock, so two stages stand between
  // it and any decode; only the second stage is read by the sequencer.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sec_s1_q <= 1'b0;
      sec_s2_q <= 1'b0;
    end else begin
      sec_s1_q <= secure_fail;
      sec_s2_q <= sec_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] prot_q, prot_d;
  logic [7:0] rdata_q, rdata_d;
  logic       refused_q, refused_d;
  logic       pump_q, pump_d;
  logic       prot_read_q, prot_read_d;

  fes_pkg::fes_state_t state_q, state_d;

  logic [15:0] lat_addr_q, lat_addr_d;
  logic [7:0]  lat_data_q, lat_data_d;

  logic prog_arm, erase_bit, whole_bit, hv_bit;
  logic in_array;
  logic latch_wr;
  logic sweep_start;
  logic sweep_busy;
  logic [AW-1:0] sweep_addr;
  logic       mem_wr;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  assign prog_arm  = ctrl_q[fes_pkg::CTRL_PROGRAM_ARM_BIT];
  assign erase_bit = ctrl_q[fes_pkg::CTRL_ERASE_BIT];
  assign whole_bit = ctrl_q[fes_pkg::CTRL_WHOLE_BIT];
  assign hv_bit    = ctrl_q[fes_pkg::CTRL_HV_BIT];
  assign in_array  = (arr_addr >= fes_pkg::ARRAY_BASE);

  // The latch write normally targets the array; in secured monitor mode it
  // goes to the protect register address instead.
  always_comb begin
    latch_wr = 1'b0;
    if (sec_s2_q) begin
      latch_wr = reg_wr && (reg_addr == fes_pkg::PROTECT_OFS);
    end else begin
      latch_wr = arr_wr && in_array;
    end
  end

  // ----------------------------------------------------------------------
  // Register file next values
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_d      = ctrl_q;
    prot_d      = prot_q;
    rdata_d     = 8'h00;
    prot_read_d = prot_read_q;
    if (reg_wr && reg_addr == fes_pkg::CTRL_OFS) begin
      ctrl_d = reg_wdata & 8'h1B;
    end
    // Protect register only changes outside any armed sequence.
    if (reg_wr && reg_addr == fes_pkg::PROTECT_OFS && !sec_s2_q && state_q == fes_pkg::ST_IDLE) begin
      prot_d = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        fes_pkg::CTRL_OFS:    rdata_d = ctrl_q;
        fes_pkg::PROTECT_OFS: rdata_d = prot_q;
        fes_pkg::STATUS_OFS:  rdata_d = {3'b000, sweep_busy, refused_q, pump_q, state_q == fes_pkg::ST_LATCHED,
                                         state_q == fes_pkg::ST_ARMED};
        default:              rdata_d = 8'h00;
      endcase
      if (reg_addr == fes_pkg::PROTECT_OFS) begin
        prot_read_d = 1'b1;
      end
    end
    // The protect read is forgotten on every return to idle, so each
    // sequence must make its own read before its latch write is taken.
    // A read left over from an earlier sequence can never arm a new one.
    if (state_q == fes_pkg::ST_IDLE) begin
      prot_read_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------------
  // Idle waits for an armed control word, armed waits for the protect read
  // and the latch write, latched waits for high voltage, and erase or
  // program run until software drops the bits that armed them.
  // The set-up, hold and recovery delays are timed by software; the
  // hardware only keeps the order of the steps.
  always_comb begin
    state_d     = state_q;
    lat_addr_d  = lat_addr_q;
    lat_data_d  = lat_data_q;
    refused_d   = refused_q;
    sweep_start = 1'b0;
    unique case (state_q)
      fes_pkg::ST_IDLE: begin
        if (prog_arm || (erase_bit && whole_bit)) begin
          state_d = fes_pkg::ST_ARMED;
        end
      end
      fes_pkg::ST_ARMED: begin
        if (!prog_arm && !(erase_bit && whole_bit)) begin
          state_d = fes_pkg::ST_IDLE;
        end else if (latch_wr && prot_read_q) begin
          // A latch write without the protect read before it is ignored;
          // software may simply repeat the read and the write.
          lat_addr_d = sec_s2_q ? fes_pkg::ARRAY_BASE : arr_addr;
          lat_data_d = sec_s2_q ? reg_wdata : arr_wdata;
          if (erase_bit && whole_bit && prot_q != fes_pkg::PROTECT_NONE) begin
            refused_d = 1'b1;
            state_d   = fes_pkg::ST_IDLE;
          end else begin
            refused_d = 1'b0;
            state_d   = fes_pkg::ST_LATCHED;
          end
        end
      end
      fes_pkg::ST_LATCHED: begin
        if (!prog_arm && !(erase_bit && whole_bit)) begin
          state_d = fes_pkg::ST_IDLE;
        end else if (hv_bit) begin
          state_d = prog_arm ? fes_pkg::ST_PROGRAM : fes_pkg::ST_ERASE;
        end
      end
      fes_pkg::ST_ERASE: begin
        // Clearing the erase bits while high voltage is on completes it.
        if (!(erase_bit && whole_bit)) begin
          sweep_start = 1'b1;
          state_d     = fes_pkg::ST_IDLE;
        end
      end
      fes_pkg::ST_PROGRAM: begin
        if (!prog_arm) begin
          state_d = fes_pkg::ST_IDLE;
        end else if (arr_wr && in_array) begin
          lat_addr_d = arr_addr;
          lat_data_d = arr_wdata;
        end
      end
      default: state_d = fes_pkg::ST_IDLE;
    endcase
  end

  // High voltage only with program-arm or erase; otherwise read mode.
  // The pump follows the state as well, so a high-voltage bit set before
  // any latch write never reaches the array.
  always_comb begin
    pump_d = hv_bit && (prog_arm || erase_bit) && (state_q == fes_pkg::ST_ERASE ||
             state_q == fes_pkg::ST_PROGRAM);
  end

  // ----------------------------------------------------------------------
  // Array write path
  // ----------------------------------------------------------------------
  // Row programming: writes outside the row of the previous latched address
  // (the latch write, then each program-state array write, even a dropped one) are dropped. The
  // byte is written as given; programming a byte twice without an erase
  // is a software error that the array does not try to model.
  always_comb begin
    mem_wr    = 1'b0;
    mem_waddr = sweep_addr;
    mem_wdata = fes_pkg::ERASED_BYTE;
    if (sweep_busy) begin
      mem_wr = 1'b1;
    end else if (state_q == fes_pkg::ST_PROGRAM && pump_q && arr_wr && in_array &&
                 arr_addr[15:fes_pkg::ROW_BITS] == lat_addr_q[15:fes_pkg::ROW_BITS]) begin
      mem_wr    = 1'b1;
      mem_waddr = arr_addr[AW-1:0];
      mem_wdata = arr_wdata;
    end
  end

  // The clear sweep takes priority over any program write and runs one
  // byte a cycle, so a whole erase keeps the array busy for its full depth.
  fes_sweep #(.AW(AW)) u_sweep (
    .clock  (clock),
    .resetn (resetn),
    .start  (sweep_start),
    .busy   (sweep_busy),
    .addr   (sweep_addr)
  );

  // Array reads come from the memory's read register, loaded at the strobe
  // edge from the address that stands on the bus in that cycle.
  fes_array_mem #(.AW(AW)) u_mem (
    .clock   (clock),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (arr_addr[AW-1:0]),
    .rd_data (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q      <= fes_pkg::CTRL_RESET;
      prot_q      <= fes_pkg::PROTECT_RESET;
      rdata_q     <= 8'h00;
      refused_q   <= 1'b0;
      pump_q      <= 1'b0;
      prot_read_q <= 1'b0;
      state_q     <= fes_pkg::ST_IDLE;
      lat_addr_q  <= 16'h0000;
      lat_data_q  <= 8'h00;
    end else begin
      ctrl_q      <= ctrl_d;
      prot_q      <= prot_d;
      rdata_q     <= rdata_d;
      refused_q   <= refused_d;
      pump_q      <= pump_d;
      prot_read_q <= prot_read_d;
      state_q     <= state_d;
      lat_addr_q  <= lat_addr_d;
      lat_data_q  <= lat_data_d;
    end
  end

  // Array reads are blocked while high voltage is applied. A cell under
  // the pump gives no stable value, so the bus sees zero instead.
  logic arr_rd_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arr_rd_q <= 1'b0;
    end else begin
      arr_rd_q <= arr_rd && !pump_q;
    end
  end

  // Outputs. Array read data stand only in the cycle after the strobe and
  // read as zero when the read was taken with the pump on.
  assign reg_rdata     = rdata_q;
  assign arr_rdata     = arr_rd_q ? mem_rdata : 8'h00;
  assign pump_on       = pump_q;
  assign erase_refused = refused_q;

endmodule
`default_nettype wire

// File: tb/fes_cpu_model.sv
// Software model that walks the erase and program steps on the bus.
`timescale 1ns/100ps
`default_nettype none
module fes_cpu_model (
  // Clock.
  input  wire logic        clock,
  // Register port.
  output logic      [3:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  // Array port.
  output logic      [15:0] arr_addr,
  output logic      [7:0]  arr_wdata,
  output logic             arr_wr,
  output logic             arr_rd,
  input  wire logic [7:0]  arr_rdata
);
  // --------
  // Bus cycles
  // --------
  localparam logic [15:0] CT = {12'h000, fes_pkg::CTRL_OFS};
  localparam logic [15:0] PR = {12'h000, fes_pkg::PROTECT_OFS};
  localparam logic [15:0] ST = {12'h000, fes_pkg::STATUS_OFS};

  // Everything idle from time zero.
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
    {arr_addr, arr_wdata, arr_wr, arr_rd} = 26'h0000000;
  end

  // One strobe after idle beats; data lines turn over on release so a stale value never looks valid.
  task automatic cyc(input bit rp, input bit wr, input logic [15:0] a,
                     input logic [7:0] d, input int idle, output logic [7:0] q);
    repeat (idle) @(posedge clock);
    @(posedge clock);
    reg_addr  <= a[3:0];
    arr_addr  <= a;
    reg_wdata <= d;
    arr_wdata <= d;
    reg_wr    <= rp && wr;
    reg_rd    <= rp && !wr;
    arr_wr    <= !rp && wr;
    arr_rd    <= !rp && !wr;
    @(posedge clock);
    {reg_wr, reg_rd, arr_wr, arr_rd} <= 4'h0;
    reg_wdata <= ~d;
    arr_wdata <= ~d;
    #1 q = rp ? reg_rdata : arr_rdata;
  endtask

  // Whole erase; the status read after the latch shows a refusal. The sweep outlives the task.
  task automatic erase_seq(input int idle, output logic [7:0] stat);
    logic [7:0] q;
    cyc(1, 1, CT, 8'h0A, idle, q);
    cyc(1, 0, PR, 8'h00, idle, q);
    cyc(0, 1, fes_pkg::ARRAY_BASE, 8'h00, idle, q);
    cyc(1, 0, ST, 8'h00, idle, stat);
    cyc(1, 1, CT, 8'h1A, idle, q);
    cyc(1, 1, CT, 8'h10, idle + 8, q);
    cyc(1, 1, CT, 8'h00, idle, q);
  endtask

  // Two bytes into the latched row, with a read under high voltage in between.
  task automatic prog_seq(input logic [15:0] row, a0, a1, input logic [7:0] d0, d1);
    logic [7:0] q;
    cyc(1, 1, CT, 8'h01, 0, q);
    cyc(1, 0, PR, 8'h00, 1, q);
    cyc(0, 1, row, 8'h00, 0, q);
    cyc(1, 1, CT, 8'h11, 2, q);
    cyc(0, 1, a0, d0, 4, q);
    cyc(0, 0, a0, 8'h00, 0, q);
    cyc(0, 1, a1, d1, 1, q);
    cyc(1, 1, CT, 8'h10, 1, q);
    cyc(1, 1, CT, 8'h00, 2, q);
  endtask
endmodule
`default_nettype wire

// File: tb/fes_sequencer_asserts.sv
// Port checks for the sequencer, bound to it.
`timescale 1ns/100ps
`default_nettype none
module fes_sequencer_asserts #(
  parameter int AW = 12
) (
  // Clock and reset.
  input wire logic       clock,
  input wire logic       resetn,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Array port, pump and erase refusal.
  input wire logic       arr_wr,
  input wire logic       arr_rd,
  input wire logic [7:0] arr_rdata,
  input wire logic       pump_on,
  input wire logic       erase_refused
);
  // --------
  // Shadows
  // --------
  // Copies of what software wrote, since the design's registers are out of sight.
  logic [7:0] ctrl_q, ctrl_d, prot_q, prot_d;
  logic       hv_arm;
  assign hv_arm = ctrl_q[4] && (ctrl_q[0] || ctrl_q[1]);

  // Next shadow values.
  always_comb begin
    ctrl_d = ctrl_q;
    prot_d = prot_q;
    if (reg_wr && reg_addr == fes_pkg::CTRL_OFS) ctrl_d = reg_wdata;
    if (reg_wr && reg_addr == fes_pkg::PROTECT_OFS) prot_d = reg_wdata;
  end

  // Shadow registers.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= fes_pkg::CTRL_RESET;
      prot_q <= fes_pkg::PROTECT_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      prot_q <= prot_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_pump_needs_arm: assert property (pump_on |-> hv_arm || $past(hv_arm))
    else $error("pump on without an armed high voltage");
  a_hv_off_drops: assert property (reg_wr && reg_addr == fes_pkg::CTRL_OFS && !reg_wdata[4] |-> ##2 !pump_on)
    else $error("pump still on after high voltage cleared");
  a_read_blind: assert property (arr_rd && pump_on |=> arr_rdata == 8'h00)
    else $error("array read data under high voltage");
  a_ctrl_readback: assert property (reg_rd && reg_addr == fes_pkg::CTRL_OFS |=> reg_rdata == ($past(ctrl_q) & 8'h1B))
    else $error("control readback wrong");
  a_refuse_protected: assert property ($rose(erase_refused) |-> prot_q != fes_pkg::PROTECT_NONE)
    else $error("erase refused while unprotected");
  a_no_refuse_open: assert property (arr_wr && ctrl_q[1] && ctrl_q[3] && prot_q == 8'hFF |=> !$rose(erase_refused))
    else $error("unprotected erase refused");
endmodule

bind fes_sequencer fes_sequencer_asserts #(.AW(AW)) i_fes_sequencer_asserts (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_rd(arr_rd), .arr_rdata(arr_rdata),
  .pump_on(pump_on), .erase_refused(erase_refused));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the flash erase and program sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clock, resetn, secure_fail, reg_wr, reg_rd, arr_wr, arr_rd, pump_on, erase_refused;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, arr_wdata, arr_rdata, s;
  logic [15:0] arr_addr;
  int          fail_count, comparisons;
  // Row program results: first and last row byte, bytes outside the row, trim row.
  localparam logic [15:0] PA [6] = '{16'hF020, 16'hF03F, 16'hF040, 16'hF01F, 16'hFFC0, 16'hFFC1};
  localparam logic [7:0]  PD [6] = '{8'hA5, 8'h3C, 8'hFF, 8'hFF, 8'h12, 8'h34};

  fes_sequencer #(.AW(12)) i_fes_sequencer (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_wr(arr_wr), .arr_rd(arr_rd), .arr_rdata(arr_rdata), .secure_fail(secure_fail),
    .pump_on(pump_on), .erase_refused(erase_refused));
  fes_cpu_model i_fes_cpu_model (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr),
    .arr_rd(arr_rd), .arr_rdata(arr_rdata));

  // 200 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reads a register (rp set) or an array byte and compares it.
  task automatic rd(input bit rp, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_fes_cpu_model.cyc(rp, 1'b0, a, 8'h00, 0, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_fes_cpu_model.cyc(1'b1, 1'b1, a, d, 0, q);
  endtask

  // Polls the sweep busy bit; the clear runs one byte a cycle, so the bound of 1000 six-cycle polls covers its 4096 cycles.
  task automatic wait_sweep();
    logic [7:0] q;
    for (int i = 0; i < 1000; i++) begin
      i_fes_cpu_model.cyc(1'b1, 1'b0, 16'h0002, 8'h00, 4, q);
      if (q[4] === 1'b0) return;
    end
    fail_count++;
    stop_test();
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    resetn      = 1'b0;
    secure_fail = 1'b0;
    fail_count  = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rd(1, 16'h0000, fes_pkg::CTRL_RESET);
    rd(1, 16'h0001, fes_pkg::PROTECT_RESET);
    rd(1, 16'h0002, 8'h00);
    rd(1, 16'h000F, 8'h00);
    wr(16'h0000, 8'hE4);
    rd(1, 16'h0000, 8'h00);
    // Unprotected whole erase, trim byte included.
    i_fes_cpu_model.erase_seq(0, s);
    check({7'h00, erase_refused}, 8'h00);
    wait_sweep();
    rd(0, 16'hF020, fes_pkg::ERASED_BYTE);
    rd(0, fes_pkg::TRIM_ADDR, 8'hFF);
    i_fes_cpu_model.prog_seq(16'hF020, 16'hF020, 16'hF03F, 8'hA5, 8'h3C);
    i_fes_cpu_model.prog_seq(16'hFFC0, 16'hFFC0, 16'hFFC1, 8'h12, 8'h34);
    i_fes_cpu_model.prog_seq(16'hF020, 16'hF040, 16'hF01F, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) rd(0, PA[i], PD[i]);
    // High voltage alone must not reach the array.
    wr(16'h0000, 8'h10);
    repeat (4) @(posedge clock);
    #1 check({7'h00, pump_on}, 8'h00);
    wr(16'h0000, 8'h00);
    // A protected block blocks the whole erase, slow software this time.
    wr(16'h0001, 8'h7F);
    i_fes_cpu_model.erase_seq(3, s);
    check({7'h00, s[3]}, 8'h01);
    check({7'h00, erase_refused}, 8'h01);
    rd(0, 16'hF020, 8'hA5);
    wr(16'h0001, fes_pkg::PROTECT_NONE);
    // Secured monitor mode: the latch write goes to the protect register.
    @(posedge clock);
    secure_fail <= 1'b1;
    repeat (3) @(posedge clock);
    wr(16'h0000, 8'h0A);
    rd(1, 16'h0001, fes_pkg::PROTECT_NONE);
    wr(16'h0001, 8'h00);
    rd(1, 16'h0002, 8'h02);
    wr(16'h0000, 8'h1A);
    wr(16'h0000, 8'h10);
    wr(16'h0000, 8'h00);
    wait_sweep();
    rd(0, 16'hF020, fes_pkg::ERASED_BYTE);
    rd(1, 16'h0001, fes_pkg::PROTECT_NONE);
    @(posedge clock);
    secure_fail <= 1'b0;
    repeat (3) @(posedge clock);
    wr(16'h0001, fes_pkg::PROTECT_NONE);
    i_fes_cpu_model.erase_seq(3, s);
    wait_sweep();
    rd(0, fes_pkg::TRIM_ADDR, 8'hFF);
    rd(0, 16'hF03F, 8'hFF);
    stop_test();
  end
endmodule
`default_nettype wire
